// file: design/ceuc_pkg.sv
package ceuc_pkg;
  // Channel codes of the request and reply frames
  localparam logic [7:0] CH_SUPERVISOR = 8'h00;
  localparam logic [7:0] CH_JTAG = 8'h13;
  localparam logic [7:0] CH_CONVERTER = 8'h14;

  // Command codes
  localparam logic [7:0] write_enable_group1_cmd = 8'h02;
  localparam logic [7:0] read_enable_group1_cmd = 8'h03;
  localparam logic [7:0] write_enable_group2_cmd = 8'h04;
  localparam logic [7:0] read_enable_group2_cmd = 8'h05;
  localparam logic [7:0] write_enable_group3_cmd = 8'h06;
  localparam logic [7:0] read_enable_group3_cmd = 8'h07;
  localparam logic [7:0] read_chip_identity_cmd = 8'hD1;
  localparam logic [7:0] read_chip_identity_v1_cmd = 8'h91;
  localparam logic [7:0] read_upset_count_cmd = 8'hF1;
  localparam logic [7:0] clear_upset_count_cmd = 8'hF0;

  // Error field bit positions
  localparam int ERR_CHANNEL = 1;
  localparam int ERR_COMMAND = 2;
  localparam int ERR_TRANS = 3;
  localparam int ERR_LENGTH = 4;
  localparam logic [7:0] ERR_NONE = 8'h00;

  // Reserved transaction numbers
  localparam logic [7:0] TRN_RSV_LO = 8'h00;
  localparam logic [7:0] TRN_RSV_HI = 8'hFF;

  // Reply lengths in bytes
  localparam logic [7:0] LEN_NONE = 8'h00;
  localparam logic [7:0] LEN_WORD = 8'h04;

  // Reset values and implemented bits
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [31:0] UPSET_RESET = 32'h0000_0000;
  localparam logic [7:0] GROUP1_IMPL = 8'hFE;
  localparam logic [7:0] GROUP2_IMPL = 8'hFF;
  localparam logic [7:0] GROUP3_IMPL = 8'h1F;

  // Channel count, and the jtag and converter bits within group 3
  localparam int NUM_CHANNELS = 20;
  localparam int GROUP3_JTAG_BIT = 3;
  localparam int GROUP3_CONV_BIT = 4;

  typedef enum logic {ST_IDLE, ST_REPLY} ceuc_state_e;
endpackage : ceuc_pkg

// file: design/ceuc_sync2.sv
`timescale 1ns/1ps
module ceuc_sync2 #(
  parameter int WIDTH = 24
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // Elaboration check only, builds no hardware
  if (WIDTH < 1) begin : g_bad_width
    $error("ceuc_sync2: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : ceuc_sync2

// file: design/ceuc_chan_gate.sv
`timescale 1ns/1ps
module ceuc_chan_gate #(
  parameter int N = 20
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [N-1:0] enable,
  output logic [N-1:0] clk_run,
  output logic [N-1:0] hold_rst
);
  logic [N-1:0] next_clk_run;
  logic [N-1:0] next_hold_rst;

  // Elaboration check only, builds no hardware
  if (N < 1) begin : g_bad_count
    $error("ceuc_chan_gate: N must be at least 1");
  end

  // Disabled channel: clock stopped and reset held, state lost
  always_comb begin
    next_clk_run = enable;
    next_hold_rst = ~enable;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      clk_run <= '0;
      hold_rst <= '1;
    end else begin
      clk_run <= next_clk_run;
      hold_rst <= next_hold_rst;
    end
  end
endmodule : ceuc_chan_gate

// file: design/ceuc_top.sv
`timescale 1ns/1ps
module ceuc_top
  import ceuc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_channel,
  input wire logic [7:0] req_trn,
  input wire logic [7:0] req_len,
  input wire logic [7:0] req_cmd,
  input wire logic [31:0] req_data,
  output logic rep_valid,
  input wire logic rep_ready,
  output logic [7:0] rep_channel,
  output logic [7:0] rep_trn,
  output logic [7:0] rep_len,
  output logic [7:0] rep_err,
  output logic [31:0] rep_data,
  input wire logic upset_corrected,
  input wire logic [23:0] chip_id_fuse,
  output logic [7:0] channel_enable_group1,
  output logic [7:0] channel_enable_group2,
  output logic [7:0] channel_enable_group3,
  output logic [NUM_CHANNELS-1:0] chan_clk_run,
  output logic [NUM_CHANNELS-1:0] chan_hold_rst
);

  ////////////////////////////////////////////////////////////////////////
  // Identity and channel gating

  logic [23:0] chip_id;
  logic [NUM_CHANNELS-1:0] chan_enable;
  logic i2c_master5_on;
  logic i2c_master12_on;
  logic i2c_master13_on;
  logic i2c_master15_on;
  logic jtag_master_on;
  logic converter_channel_on;

  // Fuse lines are static but come from outside the clock domain
  ceuc_sync2 #(
    .WIDTH(24)
  ) u_id_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in(chip_id_fuse),
    .sync_out(chip_id)
  );

  assign i2c_master5_on = channel_enable_group2[0];
  assign i2c_master12_on = channel_enable_group2[7];
  assign i2c_master13_on = channel_enable_group3[0];
  assign i2c_master15_on = channel_enable_group3[2];
  assign jtag_master_on = channel_enable_group3[GROUP3_JTAG_BIT];
  assign converter_channel_on =
    channel_enable_group3[GROUP3_CONV_BIT];

  // Order: spi, gpio, i2c 0..15, jtag, converter
  assign chan_enable = {
    converter_channel_on,
    jtag_master_on,
    i2c_master15_on,
    channel_enable_group3[1],
    i2c_master13_on,
    i2c_master12_on,
    channel_enable_group2[6:1],
    i2c_master5_on,
    channel_enable_group1[7:1]
  };

  ceuc_chan_gate #(
    .N(NUM_CHANNELS)
  ) u_gate (
    .mclk(mclk),
    .srst(srst),
    .enable(chan_enable),
    .clk_run(chan_clk_run),
    .hold_rst(chan_hold_rst)
  );

  ////////////////////////////////////////////////////////////////////////
  // Request decode

  logic take;
  logic ch_sup;
  logic ch_jtag;
  logic ch_conv;
  logic cmd_known;
  logic chan_known;
  logic trn_bad;
  logic len_bad;
  logic is_write;
  logic req_ok;
  logic [7:0] val_byte;

  assign req_ready = ~rep_valid;
  assign take = req_valid & req_ready;
  assign val_byte = req_data[31:24];
  assign ch_sup = (req_channel == CH_SUPERVISOR);
  assign ch_jtag = (req_channel == CH_JTAG);
  assign ch_conv = (req_channel == CH_CONVERTER);
  assign chan_known = ch_sup | ch_jtag | ch_conv;
  assign trn_bad = (req_trn == TRN_RSV_LO) | (req_trn == TRN_RSV_HI);

  always_comb begin
    cmd_known = 1'b0;
    is_write = 1'b0;
    if (ch_sup) begin
      unique case (req_cmd)
        write_enable_group1_cmd,
        write_enable_group2_cmd,
        write_enable_group3_cmd: begin
          cmd_known = 1'b1;
          is_write = 1'b1;
        end
        read_enable_group1_cmd,
        read_enable_group2_cmd,
        read_enable_group3_cmd: begin
          cmd_known = 1'b1;
        end
        default: begin
          cmd_known = 1'b0;
        end
      endcase
    end else if (ch_jtag) begin
      cmd_known = (req_cmd == read_upset_count_cmd) |
                  (req_cmd == clear_upset_count_cmd);
    end else if (ch_conv) begin
      // Both silicon generations' opcodes are served
      cmd_known = (req_cmd == read_chip_identity_cmd) |
                  (req_cmd == read_chip_identity_v1_cmd);
    end
  end

  // A write without its value byte is refused, nothing changes
  assign len_bad = is_write & (req_len == LEN_NONE);
  assign req_ok = chan_known & cmd_known & ~trn_bad & ~len_bad;

  ////////////////////////////////////////////////////////////////////////
  // Enable registers

  logic [7:0] next_group1;
  logic [7:0] next_group2;
  logic [7:0] next_group3;

  always_comb begin
    next_group1 = channel_enable_group1;
    next_group2 = channel_enable_group2;
    next_group3 = channel_enable_group3;
    if (take & req_ok & ch_sup) begin
      if (req_cmd == write_enable_group1_cmd) begin
        next_group1 = val_byte & GROUP1_IMPL;
      end
      if (req_cmd == write_enable_group2_cmd) begin
        next_group2 = val_byte & GROUP2_IMPL;
      end
      if (req_cmd == write_enable_group3_cmd) begin
        // Unassigned bits are not stored and read as zero
        next_group3 = val_byte & GROUP3_IMPL;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      channel_enable_group1 <= ENABLE_RESET;
      channel_enable_group2 <= ENABLE_RESET;
      channel_enable_group3 <= ENABLE_RESET;
    end else begin
      channel_enable_group1 <= next_group1;
      channel_enable_group2 <= next_group2;
      channel_enable_group3 <= next_group3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Upset counter

  logic [31:0] upset_event_counter;
  logic [31:0] next_upset;
  logic upset_clear;

  assign upset_clear = take & req_ok & ch_jtag &
                       (req_cmd == clear_upset_count_cmd);

  // An upset in the clearing cycle is kept: count restarts at one
  always_comb begin
    next_upset = upset_event_counter;
    if (upset_clear) begin
      next_upset = UPSET_RESET;
    end
    if (upset_corrected) begin
      next_upset = next_upset + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      upset_event_counter <= UPSET_RESET;
    end else begin
      upset_event_counter <= next_upset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reply

  ceuc_state_e state;
  ceuc_state_e next_state;
  logic [7:0] next_rep_channel;
  logic [7:0] next_rep_trn;
  logic [7:0] next_rep_len;
  logic [7:0] next_rep_err;
  logic [31:0] next_rep_data;

  always_comb begin
    next_state = state;
    next_rep_channel = rep_channel;
    next_rep_trn = rep_trn;
    next_rep_len = rep_len;
    next_rep_err = rep_err;
    next_rep_data = rep_data;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_REPLY;
          next_rep_channel = req_channel;
          next_rep_trn = req_trn;
          next_rep_len = LEN_NONE;
          next_rep_err = ERR_NONE;
          next_rep_data = '0;
          if (!chan_known) begin
            next_rep_err[ERR_CHANNEL] = 1'b1;
          end else if (!cmd_known) begin
            next_rep_err[ERR_COMMAND] = 1'b1;
          end
          if (trn_bad) begin
            next_rep_err[ERR_TRANS] = 1'b1;
          end
          if (len_bad) begin
            next_rep_err[ERR_LENGTH] = 1'b1;
          end
          if (req_ok) begin
            if (ch_sup) begin
              if (req_cmd == read_enable_group1_cmd) begin
                next_rep_len = LEN_WORD;
                next_rep_data[31:24] = channel_enable_group1;
              end
              if (req_cmd == read_enable_group2_cmd) begin
                next_rep_len = LEN_WORD;
                next_rep_data[31:24] = channel_enable_group2;
              end
              if (req_cmd == read_enable_group3_cmd) begin
                next_rep_len = LEN_WORD;
                next_rep_data[31:24] = channel_enable_group3;
              end
            end else if (ch_jtag) begin
              if (req_cmd == read_upset_count_cmd) begin
                next_rep_len = LEN_WORD;
                next_rep_data = upset_event_counter;
              end
            end else begin
              next_rep_len = LEN_WORD;
              next_rep_data[23:0] = chip_id;
            end
          end
        end
      end
      ST_REPLY: begin
        // One outstanding request; new ones wait on req_ready
        if (rep_ready) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
      rep_channel <= CH_SUPERVISOR;
      rep_trn <= TRN_RSV_LO;
      rep_len <= LEN_NONE;
      rep_err <= ERR_NONE;
      rep_data <= '0;
    end else begin
      state <= next_state;
      rep_channel <= next_rep_channel;
      rep_trn <= next_rep_trn;
      rep_len <= next_rep_len;
      rep_err <= next_rep_err;
      rep_data <= next_rep_data;
    end
  end

  assign rep_valid = (state == ST_REPLY);
endmodule : ceuc_top

// file: tb/ceuc_checker_asserts.sv
`timescale 1ns/1ps
module ceuc_checker
  import ceuc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_channel,
  input wire logic [7:0] req_trn,
  input wire logic [7:0] req_len,
  input wire logic [7:0] req_cmd,
  input wire logic [31:0] req_data,
  input wire logic rep_valid,
  input wire logic rep_ready,
  input wire logic [7:0] rep_len,
  input wire logic [7:0] rep_err,
  input wire logic [31:0] rep_data,
  input wire logic [7:0] channel_enable_group2,
  input wire logic [7:0] channel_enable_group3,
  input wire logic [NUM_CHANNELS-1:0] chan_clk_run,
  input wire logic [NUM_CHANNELS-1:0] chan_hold_rst
);
  default clocking cb @(posedge mclk);
  endclocking
  ////////////////////////////////////////////////////////////////////
  sequence s_take;
    req_valid && req_ready && req_trn != TRN_RSV_LO
      && req_trn != TRN_RSV_HI && req_len != 8'h00;
  endsequence
  sequence s_sup(logic [7:0] c);
    s_take ##0 req_channel == CH_SUPERVISOR && req_cmd == c;
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_reply_next: assert property (disable iff (srst)
    req_valid && req_ready |=> rep_valid)
    else $error("reply did not follow request");
  a_reply_held: assert property (disable iff (srst)
    rep_valid && !rep_ready |=> rep_valid && $stable(rep_data)
      && $stable(rep_err))
    else $error("reply dropped or changed before consumed");
  a_write_grp2: assert property (disable iff (srst)
    s_sup(write_enable_group2_cmd) |=>
      channel_enable_group2 == $past(req_data[31:24]))
    else $error("group2 write lost");
  a_write_grp3: assert property (disable iff (srst)
    s_sup(write_enable_group3_cmd) |=>
      channel_enable_group3 == ($past(req_data[31:24]) & GROUP3_IMPL))
    else $error("group3 write lost");
  a_write_ok: assert property (disable iff (srst)
    s_sup(write_enable_group2_cmd) |=> rep_err == ERR_NONE
      && rep_len == LEN_NONE)
    else $error("write reply not clean");
  a_read_grp2: assert property (disable iff (srst)
    s_sup(read_enable_group2_cmd) |=>
      rep_data[31:24] == $past(channel_enable_group2))
    else $error("group2 read wrong");
  a_reset_clears: assert property (
    srst |=> channel_enable_group2 == ENABLE_RESET
      && channel_enable_group3 == ENABLE_RESET && !rep_valid)
    else $error("reset did not clear");
  a_gate_follows: assert property (disable iff (srst)
    !$past(srst) |-> chan_clk_run[19:7] ==
      $past({channel_enable_group3[4:0], channel_enable_group2}))
    else $error("channel gating does not follow enables");
  a_hold_inverse: assert property (disable iff (srst)
    chan_hold_rst == ~chan_clk_run)
    else $error("channel reset not inverse of clock run");
  a_grp3_unused: assert property (disable iff (srst)
    channel_enable_group3[7:5] == 3'h0)
    else $error("group3 unused bits set");
endmodule : ceuc_checker

bind ceuc_top ceuc_checker chk_i (.mclk, .srst, .req_valid, .req_ready,
  .req_channel, .req_trn, .req_len, .req_cmd, .req_data, .rep_valid,
  .rep_ready, .rep_len, .rep_err, .rep_data, .channel_enable_group2,
  .channel_enable_group3, .chan_clk_run, .chan_hold_rst);

// file: tb/ceuc_link_master.sv
`timescale 1ns/1ps
module ceuc_link_master (
  input wire logic mclk,
  output logic req_valid,
  input wire logic req_ready,
  output logic [7:0] req_channel,
  output logic [7:0] req_trn,
  output logic [7:0] req_len,
  output logic [7:0] req_cmd,
  output logic [31:0] req_data,
  input wire logic rep_valid,
  output logic rep_ready,
  input wire logic [7:0] rep_err,
  input wire logic [31:0] rep_data,
  input wire logic [7:0] rep_channel,
  input wire logic [7:0] rep_trn,
  input wire logic [7:0] rep_len
);
  // Cycles the reply is left waiting
  int stall = 0;
  // Length byte sent with each request
  logic [7:0] req_bytes = 8'h04;
  initial begin
    req_valid = 1'b0;
    rep_ready = 1'b0;
    {req_channel, req_trn, req_len, req_cmd, req_data} = '0;
  end
  task automatic xfer(input logic [7:0] ch, input logic [7:0] cmd,
      input logic [7:0] trn, input logic [31:0] d,
      output logic [7:0] err, output logic [31:0] rd,
      output logic [7:0] rch, output logic [7:0] rtrn,
      output logic [7:0] rlen);
    int n;
    bit hung;
    hung = 1'b0;
    @(posedge mclk);
    {req_channel, req_cmd, req_trn, req_data} <= {ch, cmd, trn, d};
    req_len <= req_bytes;
    req_valid <= 1'b1;
    @(negedge mclk);
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge mclk);
    if (req_ready !== 1'b1) begin
      hung = 1'b1;
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    // Released lines show junk, not the last value
    {req_channel, req_cmd, req_trn, req_data} <= ~{ch, cmd, trn, d};
    repeat (stall) @(posedge mclk);
    rep_ready <= 1'b1;
    @(negedge mclk);
    for (n = 0; n < 20 && rep_valid !== 1'b1; n++) @(negedge mclk);
    if (rep_valid !== 1'b1) begin
      hung = 1'b1;
    end
    err = rep_err;
    rd = rep_data;
    rch = rep_channel;
    rtrn = rep_trn;
    rlen = rep_len;
    // A lost handshake reads error, data and transaction as unknown so those compares fail
    if (hung) begin
      err = 'x;
      rd = 'x;
      rtrn = 'x;
    end
    @(posedge mclk);
    rep_ready <= 1'b0;
  endtask : xfer
endmodule : ceuc_link_master

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ceuc_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic upset_corrected = 1'b0;
  // Arbitrary serial number
  logic [23:0] chip_id_fuse = 24'h5A3C96;
  logic req_valid, req_ready, rep_valid, rep_ready;
  logic [7:0] req_channel, req_trn, req_len, req_cmd, rep_err, trn = 8'h01;
  logic [31:0] req_data, rep_data;
  logic [7:0] rep_channel, rep_trn, rep_len;
  logic [7:0] channel_enable_group1, channel_enable_group2;
  logic [7:0] channel_enable_group3;
  logic [NUM_CHANNELS-1:0] chan_clk_run, chan_hold_rst;
  int errors = 0;
  int comparisons = 0;
  always #12.5 mclk = ~mclk;
  ceuc_top dut (.mclk, .srst, .req_valid, .req_ready, .req_channel,
    .req_trn, .req_len, .req_cmd, .req_data, .rep_valid, .rep_ready,
    .rep_channel, .rep_trn, .rep_len, .rep_err, .rep_data,
    .upset_corrected, .chip_id_fuse, .channel_enable_group1,
    .channel_enable_group2, .channel_enable_group3, .chan_clk_run,
    .chan_hold_rst);
  ceuc_link_master m (.mclk, .req_valid, .req_ready, .req_channel,
    .req_trn, .req_len, .req_cmd, .req_data, .rep_valid, .rep_ready,
    .rep_err, .rep_data, .rep_channel, .rep_trn, .rep_len);
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(input logic [7:0] ch, input logic [7:0] cmd,
      input logic [31:0] d, input logic [7:0] e_err,
      input logic [31:0] e_dat, input logic [31:0] msk);
    logic [7:0] err, rch, rtrn, rlen, e_len;
    logic [31:0] rd;
    e_len = LEN_NONE;
    if (e_err == ERR_NONE && cmd inside {read_enable_group1_cmd,
        read_enable_group2_cmd, read_enable_group3_cmd,
        read_upset_count_cmd, read_chip_identity_cmd,
        read_chip_identity_v1_cmd}) begin
      e_len = LEN_WORD;
    end
    m.xfer(ch, cmd, trn, d, err, rd, rch, rtrn, rlen);
    chk("rep_channel", 32'(ch), 32'(rch));
    chk("rep_trn", 32'(trn), 32'(rtrn));
    chk("rep_len", 32'(e_len), 32'(rlen));
    trn++;
    chk("rep_err", 32'(e_err), 32'(err));
    chk("rep_data", e_dat, rd & msk);
  endtask : op
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("group2", 32'h0, 32'(channel_enable_group2));
    chk("group3", 32'h0, 32'(channel_enable_group3));
    chk("hold_rst", 32'h000F_FFFF, 32'(chan_hold_rst));
    op(CH_JTAG, read_upset_count_cmd, 32'h0, ERR_NONE, 32'h0, '1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_groups;
    op(CH_SUPERVISOR, write_enable_group2_cmd, 32'hA500_0000, ERR_NONE,
      32'h0, '1);
    op(CH_SUPERVISOR, read_enable_group2_cmd, 32'h0, ERR_NONE,
      32'hA500_0000, 32'hFF00_0000);
    op(CH_SUPERVISOR, write_enable_group3_cmd, 32'hFF00_0000, ERR_NONE,
      32'h0, '1);
    op(CH_SUPERVISOR, read_enable_group3_cmd, 32'h0, ERR_NONE,
      32'h1F00_0000, 32'hFF00_0000);
    op(CH_SUPERVISOR, write_enable_group1_cmd, 32'hFF00_0000, ERR_NONE,
      32'h0, '1);
    op(CH_SUPERVISOR, read_enable_group1_cmd, 32'h0, ERR_NONE,
      32'hFE00_0000, 32'hFF00_0000);
    chk("clk_run", 32'({5'h1F, 8'hA5, 7'h7F}), 32'(chan_clk_run));
    chk("hold_rst", 32'({5'h0, 8'h5A, 7'h0}), 32'(chan_hold_rst));
    $display("t_groups done");
  endtask : t_groups
  task automatic t_upset;
    repeat (3) begin
      @(posedge mclk);
      upset_corrected <= 1'b1;
      @(posedge mclk);
      upset_corrected <= 1'b0;
    end
    op(CH_JTAG, read_upset_count_cmd, 32'h0, ERR_NONE, 32'h3, '1);
    op(CH_JTAG, clear_upset_count_cmd, 32'h0, ERR_NONE, 32'h0, '1);
    op(CH_JTAG, read_upset_count_cmd, 32'h0, ERR_NONE, 32'h0, '1);
    $display("t_upset done");
  endtask : t_upset
  task automatic t_ident;
    op(CH_CONVERTER, read_chip_identity_cmd, 32'h0, ERR_NONE,
      32'(chip_id_fuse), 32'h00FF_FFFF);
    op(CH_CONVERTER, read_chip_identity_v1_cmd, 32'h0, ERR_NONE,
      32'(chip_id_fuse), 32'h00FF_FFFF);
    $display("t_ident done");
  endtask : t_ident
  task automatic t_errors;
    m.stall = 3;
    op(8'h01, read_enable_group1_cmd, 32'h0, 8'(1 << ERR_CHANNEL),
      32'h0, '1);
    trn = TRN_RSV_LO;
    op(CH_SUPERVISOR, write_enable_group2_cmd, 32'h0, 8'(1 << ERR_TRANS),
      32'h0, '1);
    op(CH_SUPERVISOR, read_upset_count_cmd, 32'h0, 8'(1 << ERR_COMMAND),
      32'h0, '1);
    m.req_bytes = LEN_NONE;
    op(CH_SUPERVISOR, write_enable_group2_cmd, 32'h0, 8'(1 << ERR_LENGTH),
      32'h0, '1);
    m.req_bytes = LEN_WORD;
    op(CH_SUPERVISOR, read_enable_group2_cmd, 32'h0, ERR_NONE,
      32'hA500_0000, 32'hFF00_0000);
    m.stall = 0;
    $display("t_errors done");
  endtask : t_errors
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_reset;
    t_groups;
    t_upset;
    t_ident;
    t_errors;
    end_sim;
  end
  // About twenty transfers of under ten cycles each, ample margin
  initial begin
    #100000;
    errors++;
    end_sim;
  end
endmodule : testbench
